// File: include/wupr_pkg.sv
package wupr_pkg;
   // Data and counter widths.
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned T12_W = 16;
   localparam int unsigned T3_W = 8;
   localparam int unsigned NUM_IRQ = 5;
   localparam int unsigned MODE_W = 2;

   typedef logic [ADDR_W-1:0] wupr_addr_t;
   typedef logic [DATA_W-1:0] wupr_byte_t;

   // Register word offsets on the plain register port.
   localparam wupr_addr_t ADDR_CTRL = 4'h0;
   localparam wupr_addr_t ADDR_IRQEN = 4'h1;
   localparam wupr_addr_t ADDR_STATUS = 4'h2;
   localparam wupr_addr_t ADDR_APORT = 4'h3;
   localparam wupr_addr_t ADDR_ADIR = 4'h4;
   localparam wupr_addr_t ADDR_BPORT = 4'h5;
   localparam wupr_addr_t ADDR_CPORT = 4'h6;
   localparam wupr_addr_t ADDR_CDIR = 4'h7;
   localparam wupr_addr_t ADDR_DPORT = 4'h8;
   localparam wupr_addr_t ADDR_DDIR = 4'h9;
   localparam wupr_addr_t ADDR_CAP1LO = 4'ha;
   localparam wupr_addr_t ADDR_CAP1HI = 4'hb;
   localparam wupr_addr_t ADDR_CAP2LO = 4'hc;
   localparam wupr_addr_t ADDR_CAP2HI = 4'hd;
   localparam wupr_addr_t ADDR_TMR3 = 4'he;

   // Control register fields.
   localparam int unsigned CTRL_T1_SLEEP = 0;
   localparam int unsigned CTRL_T2_SLEEP = 1;
   localparam int unsigned CTRL_SER_SLEEP = 2;
   localparam int unsigned CTRL_MODE_LSB = 3;
   localparam int unsigned CTRL_T1_RUN = 5;
   localparam int unsigned CTRL_T2_RUN = 6;
   localparam int unsigned CTRL_T3_RUN = 7;
   localparam wupr_byte_t SLEEP_MASK = 8'h07;

   // Status register fields.
   localparam int unsigned STAT_DOZE = 0;
   localparam int unsigned STAT_CAUSE_LSB = 1;
   localparam int unsigned STAT_RESYNC = 6;

   // Interrupt source positions that also feed the capture latches.
   localparam int unsigned IRQ_ONE = 0;
   localparam int unsigned IRQ_THREE = 2;

   // Reset value of every register.
   localparam wupr_byte_t RST_BYTE = 8'h00;

   // Expansion strobe levels held while dozing, as bits 7..4 of port B.
   localparam logic [3:0] B_HI_DOZE = 4'h6;

   typedef enum logic {
      PWR_RUN = 1'b0,
      PWR_DOZE = 1'b1
   } wupr_pwr_e;

   typedef enum logic [1:0] {
      MODE_SINGLE = 2'b00,
      MODE_PERIPH = 2'b01,
      MODE_FULL = 2'b11,
      MODE_MPU = 2'b10
   } wupr_mode_e;
endpackage

// File: include/wupr_tmr_if.sv
`timescale 1ns/1ps
interface wupr_tmr_if #(
   parameter int unsigned W = 16
);
   logic run;
   logic capEn;
   logic capEvent;
   logic [W-1:0] latch;

   // The controller steers the timer; the timer answers with its latch.
   modport ctl (output run, output capEn, output capEvent, input latch);
   modport tmr (input run, input capEn, input capEvent, output latch);
endinterface

// File: rtl/wupr_pin_sync.sv
`timescale 1ns/1ps
module wupr_pin_sync #(
   parameter int unsigned N = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [N-1:0] pinIn,
   output logic [N-1:0] activePulse
);
   import wupr_pkg::*;

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] lvl;
      logic [N-1:0] pulse;
   } wupr_sync_s;

   wupr_sync_s st;
   wupr_sync_s next_st;

   // Three stages; a level counts once the second and third agree.
   always_comb begin
      next_st = st;
      next_st.s1 = pinIn;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < N; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.lvl[i] = st.s3[i];
         end
         // Pins are active low, so a fall of the filtered level is the event.
         next_st.pulse[i] = st.lvl[i] & ~next_st.lvl[i];
      end
   end

   // Pins idle high, so the stages start high.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{default: '1, pulse: '0};
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign activePulse = st.pulse;
endmodule // wupr_pin_sync

// File: rtl/wupr_timer.sv
`timescale 1ns/1ps
module wupr_timer #(
   parameter int unsigned W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   wupr_tmr_if.tmr bus
);
   import wupr_pkg::*;

   typedef struct packed {
      logic [W-1:0] cnt;
      logic [W-1:0] latch;
   } wupr_tmr_s;

   wupr_tmr_s st;
   wupr_tmr_s next_st;

   // Counts while allowed and holds its value while halted.
   always_comb begin
      next_st = st;
      if (bus.run) begin
         next_st.cnt = st.cnt + W'(1);
      end
      if (bus.capEvent && bus.capEn) begin
         next_st.latch = st.cnt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign bus.latch = st.latch;
endmodule // wupr_timer

// File: rtl/wupr_top.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module wupr_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [wupr_pkg::ADDR_W-1:0] regAddr,
   input wire logic [wupr_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [wupr_pkg::DATA_W-1:0] regRdata,
   input wire logic idleExec,
   input wire logic [wupr_pkg::NUM_IRQ-1:0] irqReq,
   input wire logic irq_one_pin_n,
   input wire logic irq_three_pin_n,
   input wire logic busClkIn,
   input wire logic busEnIn,
   input wire logic busRwIn,
   input wire logic busAlIn,
   input wire logic [wupr_pkg::DATA_W-1:0] busCIn,
   input wire logic busCOe,
   input wire logic [wupr_pkg::DATA_W-1:0] busDIn,
   output logic cpuHalted,
   output logic serialRun,
   output logic [wupr_pkg::DATA_W-1:0] portAOut,
   output logic [wupr_pkg::DATA_W-1:0] portAOe,
   output logic bus_clock_output,
   output logic enableStrobe,
   output logic readWrite,
   output logic address_latch_strobe,
   output logic [wupr_pkg::DATA_W-1:0] portCOut,
   output logic [wupr_pkg::DATA_W-1:0] portCOe,
   output logic [wupr_pkg::DATA_W-1:0] portDOut,
   output logic [wupr_pkg::DATA_W-1:0] portDOe
);
   import wupr_pkg::*;

   // Apart from rstPipe and the submodules, the block state lives in one record that one register process captures.
   // The output copies sit in it too, so every pin is a flip-flop and the doze
   // values appear one cycle after the power state itself, except cpuHalted, which moves with it.
   typedef struct packed {
      wupr_pwr_e pwr;
      logic [DATA_W-1:0] ctrl;
      logic [NUM_IRQ-1:0] irqEn;
      logic [NUM_IRQ-1:0] cause;
      logic resync;
      logic [DATA_W-1:0] aData;
      logic [DATA_W-1:0] aDir;
      logic [DATA_W-1:0] bData;
      logic [DATA_W-1:0] cData;
      logic [DATA_W-1:0] cDir;
      logic [DATA_W-1:0] dData;
      logic [DATA_W-1:0] dDir;
      logic [T3_W-1:0] t3Cnt;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] aOut;
      logic [DATA_W-1:0] aOe;
      logic [3:0] bHi;
      logic [DATA_W-1:0] cOut;
      logic [DATA_W-1:0] cOe;
      logic [DATA_W-1:0] dOut;
      logic [DATA_W-1:0] dOe;
      logic halted;
      logic serRun;
   } wupr_top_s;

   wupr_top_s st;
   wupr_top_s next_st;
   // The helper nets below are decodes of the state or of the inputs, except rstPipe,
   // whose two reset synchroniser flip-flops hold a value of their own.
   logic [1:0] rstPipe;
   logic rst_n;
   logic [1:0] pinEvent;
   logic [T12_W-1:0] capVal [2];
   logic doze;
   logic [1:0] tmrSleep;
   logic [1:0] tmrRunBit;
   logic serHalt;
   wupr_mode_e mode;
   logic [NUM_IRQ-1:0] wakeHit;

   // Release reset through two flip-flops; everything else uses the copy.
   // The release is delayed so that every flip-flop leaves reset on one edge.
   // The assertion of reset still acts at once.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstPipe <= '0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rst_n = rstPipe[1];

   // Filter the two capture pins; bit 0 feeds timer one, bit 1 timer two.
   // Both pins pass the same filter, so the two capture paths have equal
   // latency from the pin fall to the latch load.
   wupr_pin_sync #(
      .N(2)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .pinIn({irq_one_pin_n, irq_three_pin_n}),
      .activePulse(pinEvent)
   );

   // Decoded views of the current state.
   // The serial halt only bites while dozing; awake, the run bit alone decides.
   // Any enabled request counts as a wake source, whichever of the five it is.
   assign doze = (st.pwr == PWR_DOZE);
   assign mode = wupr_mode_e'(st.ctrl[CTRL_MODE_LSB +: MODE_W]);
   assign tmrSleep = {st.ctrl[CTRL_T2_SLEEP], st.ctrl[CTRL_T1_SLEEP]};
   assign tmrRunBit = {st.ctrl[CTRL_T2_RUN], st.ctrl[CTRL_T1_RUN]};
   assign serHalt = doze & st.ctrl[CTRL_SER_SLEEP];
   assign wakeHit = irqReq & st.irqEn;

   // Each interface carries the controls of one timer and brings its latch back.
   wupr_tmr_if #(.W(T12_W)) tmrIf [2] ();

   // Timer one and timer two share one structure; each has its own run and sleep bits.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_tmr
         // A unit selected to sleep stops counting only while dozing.
         assign tmrIf[gi].run = tmrRunBit[gi] & ~(doze & tmrSleep[gi]);
         // The interrupt enables are left out of the capture path on purpose, so a
         // latch can time an event that is not allowed to wake the core.
         // Capture obeys the sleep select while dozing, never the enables.
         assign tmrIf[gi].capEn = ~(doze & tmrSleep[gi]);
         assign tmrIf[gi].capEvent = pinEvent[gi];
         assign capVal[gi] = tmrIf[gi].latch;
         wupr_timer #(
            .W(T12_W)
         ) u_tmr (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .bus(tmrIf[gi])
         );
      end
   endgenerate

   // Register writes, power sequencing, timer three and pin outputs.
   always_comb begin
      next_st = st;

      // A write lands at the edge that samples the strobe.
      // Writes to unmapped words are dropped without trace.
      if (regWr) begin
         unique case (regAddr)
            ADDR_CTRL: begin
               if (doze) begin
                  // Halt selects are frozen for the whole sleep.
                  next_st.ctrl = (regWdata & ~SLEEP_MASK) | (st.ctrl & SLEEP_MASK);
               end else begin
                  next_st.ctrl = regWdata;
               end
            end
            ADDR_IRQEN: next_st.irqEn = regWdata[NUM_IRQ-1:0];
            ADDR_STATUS: begin
               if (regWdata[STAT_RESYNC]) begin
                  next_st.resync = 1'b0;
               end
            end
            ADDR_APORT: next_st.aData = regWdata;
            ADDR_ADIR: next_st.aDir = regWdata;
            ADDR_BPORT: next_st.bData = regWdata;
            ADDR_CPORT: next_st.cData = regWdata;
            ADDR_CDIR: next_st.cDir = regWdata;
            ADDR_DPORT: next_st.dData = regWdata;
            ADDR_DDIR: next_st.dDir = regWdata;
            default: begin
            end
         endcase
      end

      // Sleep entry and exit; the hardware set below wins over a clear.
      // Reset is the other way out; it clears the state in the register process.
      // A second idle while dozing is ignored because only the run arm reads it.
      // The wake cause is kept until the next exit overwrites it.
      unique case (st.pwr)
         PWR_RUN: begin
            if (idleExec) begin
               next_st.pwr = PWR_DOZE;
            end
         end
         PWR_DOZE: begin
            if (|wakeHit) begin
               next_st.pwr = PWR_RUN;
               next_st.cause = wakeHit;
               if (st.ctrl[CTRL_SER_SLEEP]) begin
                  next_st.resync = 1'b1;
               end
            end
         end
      endcase

      // Timer three and the serial unit hold their count while halted.
      // The counter wraps freely; software that times with it must allow for this.
      if (st.ctrl[CTRL_T3_RUN] && !serHalt) begin
         next_st.t3Cnt = st.t3Cnt + T3_W'(1);
      end

      // Read data stand in the cycle after the strobe only.
      // Clearing the word every cycle keeps stale data off the bus between reads.
      // Reads have no side effects; a repeated read differs only where hardware moved the word, as a running timer three does.
      // The two halves of a capture are read apart; software reads low first.
      next_st.rdata = RST_BYTE;
      if (regRd) begin
         unique case (regAddr)
            ADDR_CTRL: next_st.rdata = st.ctrl;
            ADDR_IRQEN: next_st.rdata = DATA_W'(st.irqEn);
            ADDR_STATUS: begin
               next_st.rdata[STAT_DOZE] = doze;
               next_st.rdata[STAT_CAUSE_LSB +: NUM_IRQ] = st.cause;
               next_st.rdata[STAT_RESYNC] = st.resync;
            end
            ADDR_APORT: next_st.rdata = st.aData;
            ADDR_ADIR: next_st.rdata = st.aDir;
            ADDR_BPORT: next_st.rdata = st.bData;
            ADDR_CPORT: next_st.rdata = st.cData;
            ADDR_CDIR: next_st.rdata = st.cDir;
            ADDR_DPORT: next_st.rdata = st.dData;
            ADDR_DDIR: next_st.rdata = st.dDir;
            ADDR_CAP1LO: next_st.rdata = capVal[0][DATA_W-1:0];
            ADDR_CAP1HI: next_st.rdata = capVal[0][T12_W-1:DATA_W];
            ADDR_CAP2LO: next_st.rdata = capVal[1][DATA_W-1:0];
            ADDR_CAP2HI: next_st.rdata = capVal[1][T12_W-1:DATA_W];
            ADDR_TMR3: next_st.rdata = st.t3Cnt;
            default: next_st.rdata = RST_BYTE;
         endcase
      end

      // Port A is plain I/O and is untouched by sleep.
      // Nothing that the doze state does reaches these two copies.
      next_st.aOut = st.aData;
      next_st.aOe = st.aDir;

      // Port B high nibble and ports C and D follow the expansion mode.
      // The mode is decoded from the live control word, so a mode change shows
      // on the pins one cycle after the write, like any other register.
      // Awake in an expansion mode, the strobes and buses come from the bus
      // controller unchanged.
      if (mode == MODE_SINGLE) begin
         next_st.bHi = st.bData[DATA_W-1:4];
         next_st.cOut = st.cData;
         next_st.cOe = st.cDir;
         next_st.dOut = st.dData;
         next_st.dOe = st.dDir;
      end else if (doze) begin
         next_st.bHi = B_HI_DOZE;
         // Address and data lines carry no meaning while asleep.
         next_st.cOut = RST_BYTE;
         next_st.cOe = RST_BYTE;
         next_st.dOut = RST_BYTE;
         next_st.dOe = RST_BYTE;
      end else begin
         next_st.bHi = {busClkIn, busEnIn, busRwIn, busAlIn};
         next_st.cOut = busCIn;
         next_st.cOe = {DATA_W{busCOe}};
         next_st.dOut = busDIn;
         next_st.dOe = {DATA_W{1'b1}};
      end

      // The halt flag follows the next power state, so it rises in the same
      // cycle as the state itself and never lags it.
      next_st.halted = (next_st.pwr == PWR_DOZE);
      next_st.serRun = st.ctrl[CTRL_T3_RUN] & ~serHalt;
   end

   // All state moves together and freezes while the clock enable is low.
   // The reset synchroniser stays outside this gate, so reset still releases
   // while the enable is low.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Every output is a flip-flop of the state.
   // Port B bits 7 to 4 map onto the four strobe pins in that order.
   assign regRdata = st.rdata;
   assign cpuHalted = st.halted;
   assign serialRun = st.serRun;
   assign portAOut = st.aOut;
   assign portAOe = st.aOe;
   assign bus_clock_output = st.bHi[3];
   assign enableStrobe = st.bHi[2];
   assign readWrite = st.bHi[1];
   assign address_latch_strobe = st.bHi[0];
   assign portCOut = st.cOut;
   assign portCOe = st.cOe;
   assign portDOut = st.dOut;
   assign portDOe = st.dOe;
endmodule // wupr_top

// File: testbench/wupr_cpu_model.sv
`timescale 1ns/1ps
module wupr_cpu_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic idleCmd,
   input wire logic [wupr_pkg::NUM_IRQ-1:0] irqCmd,
   input wire logic cpuHalted,
   output logic idleExec,
   output logic [wupr_pkg::NUM_IRQ-1:0] irqReq
);
   import wupr_pkg::*;
   // A halted core runs no code, so it issues no idle; interrupt sources are levels.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         idleExec <= 1'b0;
         irqReq <= '0;
      end else begin
         idleExec <= idleCmd && !cpuHalted && !idleExec;
         irqReq <= irqCmd;
      end
   end
endmodule // wupr_cpu_model

// File: testbench/wupr_tb_top.sv
`timescale 1ns/1ps
module wupr_tb_top;
   import wupr_pkg::*;
   logic clk, arst_n, regWr, regRd, idleCmd, idleExec, cpuHalted, serialRun;
   logic irq_one_pin_n, irq_three_pin_n, bus_clock_output, enableStrobe, readWrite;
   logic address_latch_strobe;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWdata, regRdata, portAOut, portAOe, portCOut, portCOe, portDOut, portDOe;
   logic [DATA_W-1:0] busPat = 8'h00;
   logic [NUM_IRQ-1:0] irqCmd, irqReq;
   logic [T12_W-1:0] c1, c2, o1, o2;
   wupr_byte_t d, ctl;
   wupr_mode_e modes[3] = '{MODE_PERIPH, MODE_FULL, MODE_MPU};
   int errors = 0, n_tests = 0, cycles = 0;

   wupr_top i_dut (.clk, .arst_n, .ce(1'b1), .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .idleExec, .irqReq, .irq_one_pin_n, .irq_three_pin_n, .busClkIn(busPat[0]),
      .busEnIn(busPat[1]), .busRwIn(busPat[2]), .busAlIn(busPat[3]), .busCIn(busPat),
      .busCOe(busPat[4]), .busDIn(~busPat), .cpuHalted, .serialRun, .portAOut, .portAOe,
      .bus_clock_output, .enableStrobe, .readWrite, .address_latch_strobe, .portCOut,
      .portCOe, .portDOut, .portDOe);
   wupr_cpu_model i_cpu (.clk, .arst_n, .idleCmd, .irqCmd, .cpuHalted, .idleExec, .irqReq);

   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Awake bus pattern and the hang limit.
   always @(posedge clk) begin
      busPat <= busPat + 8'h01;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input wupr_addr_t a, input wupr_byte_t v);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input wupr_addr_t a, output wupr_byte_t v);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdata;
   endtask
   task automatic rd16(input wupr_addr_t a, output logic [15:0] v);
      wupr_byte_t l, h;
      rd(a, l);
      rd(a + 4'h1, h);
      v = {h, l};
   endtask
   // One idle instruction from the core, then time for the pins to settle.
   task automatic doze();
      @(posedge clk);
      idleCmd <= 1'b1;
      @(posedge clk);
      idleCmd <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic wake(input int k);
      int i;
      irqCmd[k] <= 1'b1;
      for (i = 0; i < 8 && cpuHalted !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      irqCmd <= '0;
   endtask
   task automatic pin_fall(input bit three);
      if (three) irq_three_pin_n <= 1'b0;
      else irq_one_pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      irq_three_pin_n <= 1'b1;
      irq_one_pin_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Main sequence.
   initial begin
      arst_n = 1'b0;
      {regWr, regRd, idleCmd} = 3'h0;
      {regAddr, regWdata, irqCmd} = '0;
      {irq_one_pin_n, irq_three_pin_n} = 2'h3;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 16; i++) if (i != 14) begin
         rd(4'(i), d);
         chk("reset value", 16'h0000, 16'(d));
      end
      wr(ADDR_APORT, 8'h5a);
      wr(ADDR_ADIR, 8'h0f);
      wr(ADDR_BPORT, 8'ha0);
      wr(ADDR_CPORT, 8'h3c);
      wr(ADDR_CDIR, 8'hf0);
      wr(ADDR_DPORT, 8'h96);
      wr(ADDR_DDIR, 8'h0f);
      wr(ADDR_IRQEN, 8'h04);
      wr(ADDR_CTRL, 8'he5);
      doze();
      chk("halted", 16'h0001, 16'(cpuHalted));
      chk("port b high", 16'h000a, 16'({bus_clock_output, enableStrobe, readWrite,
         address_latch_strobe}));
      chk("port a", 16'h0f5a, {portAOe, portAOut});
      chk("port c d out", 16'h3c96, {portCOut, portDOut});
      chk("port c d oe", 16'hf00f, {portCOe, portDOe});
      irqCmd <= 5'h01;
      repeat (6) @(posedge clk);
      #1 chk("disabled irq", 16'h0001, 16'(cpuHalted));
      irqCmd <= '0;
      wr(ADDR_CTRL, 8'he0);
      repeat (3) @(posedge clk);
      #1 chk("serial halted", 16'h0000, 16'(serialRun));
      rd(ADDR_TMR3, ctl);
      repeat (4) @(posedge clk);
      rd(ADDR_TMR3, d);
      chk("timer three held", 16'(ctl), 16'(d));
      pin_fall(1'b1);
      pin_fall(1'b0);
      wake(2);
      chk("woken", 16'h0000, 16'(cpuHalted));
      rd(ADDR_STATUS, d);
      chk("status", 16'h0048, 16'(d));
      wr(ADDR_STATUS, 8'h40);
      rd(ADDR_STATUS, d);
      chk("status cleared", 16'h0008, 16'(d));
      rd(ADDR_TMR3, d);
      chk("timer three resumed", 16'h0001, 16'(d != ctl));
      rd16(ADDR_CAP1LO, c1);
      chk("cap one halted", 16'h0000, c1);
      rd16(ADDR_CAP2LO, c2);
      chk("cap two running", 16'h0001, 16'(c2 !== 16'h0000));
      pin_fall(1'b1);
      rd16(ADDR_CAP1LO, c1);
      chk("cap one awake", 16'h0001, 16'(c1 !== 16'h0000));
      // Each expansion mode, with timer two asleep in the second pass.
      for (int i = 0; i < 3; i++) begin
         ctl = {3'h7, modes[i], (i == 1) ? 3'h2 : 3'h0};
         wr(ADDR_CTRL, ctl);
         wr(ADDR_IRQEN, 8'h01);
         rd16(ADDR_CAP1LO, o1);
         rd16(ADDR_CAP2LO, o2);
         doze();
         chk("strobes", 16'h0006, 16'({bus_clock_output, enableStrobe, readWrite,
            address_latch_strobe}));
         chk("serial running", 16'h0001, 16'(serialRun));
         chk("c d doze out", 16'h0000, {portCOut, portDOut});
         chk("c d doze oe", 16'h0000, {portCOe, portDOe});
         pin_fall(1'b1);
         pin_fall(1'b0);
         wake(0);
         rd16(ADDR_CAP1LO, c1);
         rd16(ADDR_CAP2LO, c2);
         chk("cap one dozing", 16'h0001, 16'(c1 !== o1));
         chk("cap two dozing", 16'(i != 1), 16'(c2 !== o2));
      end
      wr(ADDR_IRQEN, 8'h00);
      doze();
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("reset wakes", 16'h0000, 16'(cpuHalted));
      summarize();
   end
endmodule // wupr_tb_top

// File: testbench/wupr_top_sva.sv
`timescale 1ns/1ps
module wupr_top_sva (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [wupr_pkg::ADDR_W-1:0] regAddr,
   input wire logic [wupr_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic idleExec,
   input wire logic [wupr_pkg::NUM_IRQ-1:0] irqReq,
   input wire logic cpuHalted,
   input wire logic serialRun,
   input wire logic [wupr_pkg::DATA_W-1:0] portAOut,
   input wire logic [wupr_pkg::DATA_W-1:0] portAOe,
   input wire logic bus_clock_output,
   input wire logic enableStrobe,
   input wire logic readWrite,
   input wire logic address_latch_strobe,
   input wire logic [wupr_pkg::DATA_W-1:0] portCOe,
   input wire logic [wupr_pkg::DATA_W-1:0] portDOe
);
   import wupr_pkg::*;
   wupr_byte_t ctl, ien, bDat;
   logic [1:0] hist;
   logic wake, steady, deep;
   logic [3:0] bHi;
   // Shadow copies of the registers; sleep selects cannot change while dozing.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl <= 8'h00;
         ien <= 8'h00;
         bDat <= 8'h00;
         hist <= 2'h0;
      end else begin
         hist <= {hist[0], cpuHalted};
         if (regWr && regAddr == ADDR_CTRL) ctl <= cpuHalted ? {regWdata[7:3], ctl[2:0]} : regWdata;
         if (regWr && regAddr == ADDR_IRQEN) ien <= regWdata;
         if (regWr && regAddr == ADDR_BPORT) bDat <= regWdata;
      end
   end
   // Doze that has lasted long enough for the pins to have switched.
   assign wake = |(irqReq & ien[NUM_IRQ-1:0]);
   assign steady = cpuHalted && hist[0];
   assign deep = steady && hist[1];
   assign bHi = {bus_clock_output, enableStrobe, readWrite, address_latch_strobe};
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_idle_enter: assert property (idleExec && !cpuHalted |=> cpuHalted)
      else $error("Idle instruction did not halt the core.");
   chk_wake_exit: assert property (cpuHalted && wake |-> ##[1:2] !cpuHalted)
      else $error("Enabled interrupt did not end the doze.");
   chk_stay_doze: assert property (steady && !wake && !$past(wake) |=> cpuHalted)
      else $error("Doze ended without an enabled interrupt.");
   chk_exp_strobes: assert property (steady && ctl[4:3] != MODE_SINGLE |-> bHi == 4'h6)
      else $error("Expansion strobes wrong while dozing.");
   chk_cd_float: assert property (steady && ctl[4:3] != MODE_SINGLE |-> (portCOe | portDOe) == 8'h00)
      else $error("Ports C or D driven while dozing in expansion mode.");
   chk_single_b: assert property (steady && ctl[4:3] == MODE_SINGLE |-> bHi == bDat[7:4])
      else $error("Port B high bits differ from data register while dozing.");
   chk_pin_hold: assert property (steady |-> $stable(portAOut) && $stable(portAOe))
      else $error("Port A changed while dozing.");
   chk_unit_sel: assert property (deep |-> serialRun == (ctl[7] && !ctl[2]))
      else $error("Serial unit run state differs from its sleep select.");
endmodule // wupr_top_sva

bind wupr_top wupr_top_sva i_sva (.clk, .arst_n, .regAddr, .regWdata, .regWr, .idleExec,
   .irqReq, .cpuHalted, .serialRun, .portAOut, .portAOe, .bus_clock_output, .enableStrobe,
   .readWrite, .address_latch_strobe, .portCOe, .portDOe);
